// *** live_settings_pkg.sv ***
package live_settings_pkg;

    // Report framing
    localparam int unsigned REPORT_LEN     = 64;
    localparam logic [5:0]  BYTE_LAST      = 6'h3f;
    localparam logic [5:0]  BYTE_CMD       = 6'h00;
    localparam logic [5:0]  BYTE_ROLE_0    = 6'h04;
    localparam logic [5:0]  BYTE_ROLE_8    = 6'h0c;
    localparam logic [5:0]  BYTE_OUT_LO    = 6'h0d;
    localparam logic [5:0]  BYTE_OUT_HI    = 6'h0e;
    localparam logic [5:0]  BYTE_DIR_LO    = 6'h0f;
    localparam logic [5:0]  BYTE_DIR_HI    = 6'h10;
    localparam logic [5:0]  BYTE_OPT       = 6'h11;
    localparam logic [5:0]  BYTE_STATUS    = 6'h01;

    // Command and answer codes
    localparam logic [7:0]  CMD_SET_LIVE   = 8'h21;
    localparam logic [7:0]  STATUS_OK      = 8'h00;
    localparam logic [7:0]  RSP_FILL       = 8'h00;

    // Pin role codes
    localparam logic [7:0]  ROLE_GPIO      = 8'h00;
    localparam logic [7:0]  ROLE_CS        = 8'h01;
    localparam logic [7:0]  ROLE_DEDICATED = 8'h02;

    // Option byte fields
    localparam int unsigned OPT_WAKE_BIT   = 4;
    localparam int unsigned OPT_MODE_MSB   = 3;
    localparam int unsigned OPT_MODE_LSB   = 1;
    localparam int unsigned OPT_HOLD_BIT   = 0;

    // Interrupt counting codes
    localparam logic [2:0]  CNT_OFF        = 3'h0;
    localparam logic [2:0]  CNT_FALL       = 3'h1;
    localparam logic [2:0]  CNT_RISE       = 3'h2;
    localparam logic [2:0]  CNT_LOW_PULSE  = 3'h3;
    localparam logic [2:0]  CNT_HIGH_PULSE = 3'h4;

    // Reset values of the live settings
    localparam logic [17:0] RST_ROLES      = 18'h00000;
    localparam logic [8:0]  RST_OUT        = 9'h000;
    localparam logic [8:0]  RST_DIR        = 9'h000;
    localparam logic        RST_WAKE       = 1'b0;
    localparam logic [2:0]  RST_MODE       = 3'h0;
    localparam logic        RST_HOLD       = 1'b0;

endpackage

// *** live_settings_cmd.sv ***
`timescale 1ns/1ps
module live_settings_cmd (
    input  wire logic        i_mclk,
    input  wire logic        i_rstn,
    input  wire logic        i_rx_valid,
    input  wire logic        i_rx_sof,
    input  wire logic [7:0]  i_rx_byte,
    output logic             o_rx_ready,
    output logic             o_tx_valid,
    output logic [7:0]       o_tx_byte,
    output logic             o_tx_last,
    input  wire logic        i_tx_ready,
    output logic [17:0]      o_pin_role,
    output logic [8:0]       o_default_out,
    output logic [8:0]       o_default_dir,
    output logic             o_wake_en,
    output logic [2:0]       o_int_count_mode,
    output logic             o_hold_bus,
    output logic             o_settings_loaded
);

    typedef enum logic {
        ST_RECV,
        ST_RESP
    } state_type;

    // Accepts only the three documented role codes
    function automatic logic role_known(input logic [7:0] code);
        role_known = (code == live_settings_pkg::ROLE_GPIO) ||
                     (code == live_settings_pkg::ROLE_CS) ||
                     (code == live_settings_pkg::ROLE_DEDICATED);
    endfunction

    // A byte taken at one fixed report position
    function automatic logic at_byte(input logic       take,
                                     input logic [5:0] where,
                                     input logic [5:0] pos);
        at_byte = take && (where == pos);
    endfunction

    // Counting code of the option byte; reserved codes read as off
    function automatic logic [2:0] count_mode(input logic [7:0] opt);
        logic [2:0] code;
        code = opt[live_settings_pkg::OPT_MODE_MSB:live_settings_pkg::OPT_MODE_LSB];
        // A host that breaks the reserved rule gets no counting at all
        if (code > live_settings_pkg::CNT_HIGH_PULSE) begin
            count_mode = live_settings_pkg::CNT_OFF;
        end else begin
            count_mode = code;
        end
    endfunction

    // Sequencer state
    state_type   state_q,    state_d;
    logic [5:0]  rx_cnt_q,   rx_cnt_d;
    logic        cmd_hit_q,  cmd_hit_d;

    // Staging copies, filled byte by byte
    logic [17:0] role_sh_q,  role_sh_d;
    logic [8:0]  out_sh_q,   out_sh_d;
    logic [8:0]  dir_sh_q,   dir_sh_d;
    logic [7:0]  opt_sh_q,   opt_sh_d;

    // Live settings
    logic [17:0] role_q,     role_d;
    logic [8:0]  dflt_out_q, dflt_out_d;
    logic [8:0]  dflt_dir_q, dflt_dir_d;
    logic        wake_q,     wake_d;
    logic [2:0]  mode_q,     mode_d;
    logic        hold_q,     hold_d;

    // Answer
    logic        loaded_q,   loaded_d;
    logic [5:0]  tx_cnt_q,   tx_cnt_d;
    logic [7:0]  tx_byte_q,  tx_byte_d;

    // Handshake and decode helpers
    logic [5:0]  idx;
    logic        rx_take;
    logic        tx_take;
    logic        frame_end;
    logic        commit;
    logic [8:0]  role_we;

    // Byte index: start of frame always realigns to byte 0
    assign idx        = i_rx_sof ? live_settings_pkg::BYTE_CMD : rx_cnt_q;
    assign rx_take    = i_rx_valid && (state_q == ST_RECV);
    assign tx_take    = (state_q == ST_RESP) && i_tx_ready;
    assign frame_end  = at_byte(rx_take, idx, live_settings_pkg::BYTE_LAST);

    // A report only counts when its byte 0 held the set code
    assign commit     = frame_end && cmd_hit_q;

    // Handshake outputs decode the state flop directly
    assign o_rx_ready = (state_q == ST_RECV);
    assign o_tx_valid = (state_q == ST_RESP);
    assign o_tx_last  = (state_q == ST_RESP) && (tx_cnt_q == live_settings_pkg::BYTE_LAST);

    // Sequencer: count bytes, remember the code, switch to answering
    always_comb begin
        state_d   = state_q;
        rx_cnt_d  = rx_cnt_q;
        cmd_hit_d = cmd_hit_q;
        case (state_q)
            ST_RECV: begin
                if (rx_take) begin
                    rx_cnt_d = idx + 6'h01;
                end
                if (at_byte(rx_take, idx, live_settings_pkg::BYTE_CMD)) begin
                    cmd_hit_d = (i_rx_byte == live_settings_pkg::CMD_SET_LIVE);
                end
                // Wrap after the last byte, whatever the code was
                if (frame_end) begin
                    rx_cnt_d = 6'h00;
                end
                if (commit) begin
                    state_d = ST_RESP;
                end
            end
            ST_RESP: begin
                // Input side stays closed until the host has the whole answer
                if (tx_take && (tx_cnt_q == live_settings_pkg::BYTE_LAST)) begin
                    state_d = ST_RECV;
                end
            end
            default: begin
                state_d = ST_RECV;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q   <= ST_RECV;
            rx_cnt_q  <= 6'h00;
            cmd_hit_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            rx_cnt_q  <= rx_cnt_d;
            cmd_hit_q <= cmd_hit_d;
        end
    end

    // Role write strobe per pin; an unknown code never strobes
    for (genvar n = 0; n < 9; n++) begin : g_role_we
        assign role_we[n] = at_byte(rx_take, idx, 6'(live_settings_pkg::BYTE_ROLE_0 + n)) &&
                            role_known(i_rx_byte);
    end

    // Staging: later bytes overwrite, nothing goes live yet
    always_comb begin
        role_sh_d = role_sh_q;
        out_sh_d  = out_sh_q;
        dir_sh_d  = dir_sh_q;
        opt_sh_d  = opt_sh_q;
        // Start from the live roles so a bad code leaves its pin as it is
        if (at_byte(rx_take, idx, live_settings_pkg::BYTE_CMD)) begin
            role_sh_d = role_q;
        end
        for (int n = 0; n < 9; n++) begin
            if (role_we[n]) begin
                role_sh_d[2*n +: 2] = i_rx_byte[1:0];
            end
        end

        // Output levels: low byte whole, high byte only bit 0
        if (at_byte(rx_take, idx, live_settings_pkg::BYTE_OUT_LO)) begin
            out_sh_d[7:0] = i_rx_byte;
        end
        if (at_byte(rx_take, idx, live_settings_pkg::BYTE_OUT_HI)) begin
            out_sh_d[8] = i_rx_byte[0];
        end

        // Directions: same packing as the levels
        if (at_byte(rx_take, idx, live_settings_pkg::BYTE_DIR_LO)) begin
            dir_sh_d[7:0] = i_rx_byte;
        end
        if (at_byte(rx_take, idx, live_settings_pkg::BYTE_DIR_HI)) begin
            dir_sh_d[8] = i_rx_byte[0];
        end

        // Only byte 17 is kept; 1-3 and 18-63 pass unused
        if (at_byte(rx_take, idx, live_settings_pkg::BYTE_OPT)) begin
            opt_sh_d = i_rx_byte;
        end
    end

    // Staging registers
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            role_sh_q <= live_settings_pkg::RST_ROLES;
            out_sh_q  <= live_settings_pkg::RST_OUT;
            dir_sh_q  <= live_settings_pkg::RST_DIR;
            opt_sh_q  <= 8'h00;
        end else begin
            role_sh_q <= role_sh_d;
            out_sh_q  <= out_sh_d;
            dir_sh_q  <= dir_sh_d;
            opt_sh_q  <= opt_sh_d;
        end
    end

    // Live set: replaced whole on commit, so a cut report changes nothing
    always_comb begin
        role_d     = role_q;
        dflt_out_d = dflt_out_q;
        dflt_dir_d = dflt_dir_q;
        wake_d     = wake_q;
        mode_d     = mode_q;
        hold_d     = hold_q;
        if (commit) begin
            role_d     = role_sh_q;
            dflt_out_d = out_sh_q;
            dflt_dir_d = dir_sh_q;
            // Bits 7-5 of the option byte are never looked at
            wake_d     = opt_sh_q[live_settings_pkg::OPT_WAKE_BIT];
            mode_d     = count_mode(opt_sh_q);
            hold_d     = opt_sh_q[live_settings_pkg::OPT_HOLD_BIT];
        end
    end

    // Live registers; nothing here reaches nonvolatile storage
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            role_q     <= live_settings_pkg::RST_ROLES;
            dflt_out_q <= live_settings_pkg::RST_OUT;
            dflt_dir_q <= live_settings_pkg::RST_DIR;
            wake_q     <= live_settings_pkg::RST_WAKE;
            mode_q     <= live_settings_pkg::RST_MODE;
            hold_q     <= live_settings_pkg::RST_HOLD;
        end else begin
            role_q     <= role_d;
            dflt_out_q <= dflt_out_d;
            dflt_dir_q <= dflt_dir_d;
            wake_q     <= wake_d;
            mode_q     <= mode_d;
            hold_q     <= hold_d;
        end
    end

    // Answer: code, status, then fill; one byte per take
    always_comb begin
        loaded_d  = commit;
        tx_cnt_d  = tx_cnt_q;
        tx_byte_d = tx_byte_q;
        if (commit) begin
            tx_cnt_d  = 6'h00;
            tx_byte_d = live_settings_pkg::CMD_SET_LIVE;
        end else if (tx_take && (tx_cnt_q != live_settings_pkg::BYTE_LAST)) begin
            tx_cnt_d = tx_cnt_q + 6'h01;
            // Status byte then plain fill
            if (tx_cnt_d == live_settings_pkg::BYTE_STATUS) begin
                tx_byte_d = live_settings_pkg::STATUS_OK;
            end else begin
                tx_byte_d = live_settings_pkg::RSP_FILL;
            end
        end
    end

    // Answer registers; the commit pulse lasts one cycle by design
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            loaded_q  <= 1'b0;
            tx_cnt_q  <= 6'h00;
            tx_byte_q <= 8'h00;
        end else begin
            loaded_q  <= loaded_d;
            tx_cnt_q  <= tx_cnt_d;
            tx_byte_q <= tx_byte_d;
        end
    end

    // Live settings straight from flops; mode codes 0-4
    assign o_pin_role        = role_q;
    assign o_default_out     = dflt_out_q;
    assign o_default_dir     = dflt_dir_q;
    assign o_wake_en         = wake_q;
    assign o_int_count_mode  = mode_q;
    assign o_hold_bus        = hold_q;
    assign o_settings_loaded = loaded_q;
    assign o_tx_byte         = tx_byte_q;

endmodule

// *** live_settings_cmd_assertions.sv ***
`timescale 1ns/1ps
module live_settings_cmd_checker (
    input wire logic        i_mclk,
    input wire logic        i_rstn,
    input wire logic        i_rx_valid,
    input wire logic        i_tx_ready,
    input wire logic        o_rx_ready,
    input wire logic        o_tx_valid,
    input wire logic [7:0]  o_tx_byte,
    input wire logic        o_tx_last,
    input wire logic [17:0] o_pin_role,
    input wire logic [8:0]  o_default_out,
    input wire logic [8:0]  o_default_dir,
    input wire logic [2:0]  o_int_count_mode,
    input wire logic        o_wake_en,
    input wire logic        o_hold_bus,
    input wire logic        o_settings_loaded
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    // Answer opens with the code, together with the commit pulse
    a_echo_first: assert property ($rose(o_tx_valid) |->
        o_tx_byte == 8'h21 && o_settings_loaded) else $error("answer start wrong");
    a_status_ok: assert property (o_tx_valid && i_tx_ready && o_tx_byte == 8'h21
        |=> o_tx_valid && o_tx_byte == 8'h00) else $error("status byte wrong");
    a_rx_blocked: assert property (o_tx_valid |-> !o_rx_ready)
        else $error("bytes accepted while answering");
    a_load_cause: assert property ($rose(o_tx_valid) |-> $past(i_rx_valid && o_rx_ready))
        else $error("answer without a taken byte");
    a_load_pulse: assert property (o_settings_loaded |-> $rose(o_tx_valid) ##1 !o_settings_loaded)
        else $error("commit pulse wrong");
    a_mode_legal: assert property (o_int_count_mode <= 3'h4) else $error("reserved mode");
    // A role field of 3 would mean an unknown code got through
    a_role_legal: assert property ((o_pin_role & (o_pin_role >> 1) & 18'h15555) == 18'h0)
        else $error("illegal role");
    a_live_stable: assert property (!o_settings_loaded |->
        $stable({o_pin_role, o_default_out, o_default_dir, o_int_count_mode, o_wake_en,
                 o_hold_bus}))
        else $error("settings moved without commit");
    a_last_done: assert property (o_tx_valid && o_tx_last && i_tx_ready |=>
        !o_tx_valid && o_rx_ready) else $error("answer did not end");
endmodule

bind live_settings_cmd live_settings_cmd_checker u_chk (.i_mclk(i_mclk), .i_rstn(i_rstn),
    .i_rx_valid(i_rx_valid), .i_tx_ready(i_tx_ready), .o_rx_ready(o_rx_ready),
    .o_tx_valid(o_tx_valid), .o_tx_byte(o_tx_byte), .o_tx_last(o_tx_last),
    .o_pin_role(o_pin_role), .o_default_out(o_default_out), .o_default_dir(o_default_dir),
    .o_int_count_mode(o_int_count_mode), .o_wake_en(o_wake_en), .o_hold_bus(o_hold_bus),
    .o_settings_loaded(o_settings_loaded));

// *** host_report_model.sv ***
`timescale 1ns/1ps
module host_report_model (
    input  wire logic       i_clk,
    input  wire logic       i_rx_ready,
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_byte,
    input  wire logic       i_tx_last,
    output logic            o_rx_valid,
    output logic            o_rx_sof,
    output logic [7:0]      o_rx_byte,
    output logic            o_tx_ready
);
    logic [7:0] rpt [64];
    logic [7:0] rsp [64];
    int         n_rsp;
    int         last_idx;
    initial {o_rx_valid, o_rx_sof, o_rx_byte, o_tx_ready} = '0;
    // Whole report, each byte held until taken; reserved bytes forced to zero
    task automatic send();
        for (int i = 0; i < 64; i++) begin
            o_rx_valid = 1'b1;
            o_rx_sof   = (i == 0);
            o_rx_byte  = (i inside {[1:3], [18:63]}) ? 8'h00 : rpt[i];
            do @(posedge i_clk); while (!i_rx_ready);
            #1;
        end
        {o_rx_valid, o_rx_sof} = 2'b00;
        o_rx_byte = ~o_rx_byte; // Idle data never echoes the last byte
    endtask
    // Slow mode stalls every other cycle to stretch the answer
    task automatic recv(input bit slow);
        n_rsp    = 0;
        last_idx = -1;
        for (int k = 0; k < 300 && n_rsp < 64; k++) begin
            o_tx_ready = !slow || k[0];
            @(posedge i_clk);
            if (i_tx_valid && o_tx_ready) begin
                rsp[n_rsp] = i_tx_byte;
                if (i_tx_last)
                    last_idx = n_rsp;
                n_rsp++;
            end
            #1;
        end
        o_tx_ready = 1'b0;
    endtask
endmodule

// *** test_live_settings_cmd.sv ***
`timescale 1ns/1ps
module test_live_settings_cmd;
    logic        i_mclk, i_rstn, rx_valid, rx_sof, rx_ready, tx_valid, tx_last, tx_ready;
    logic        loaded, wake, hold, exp_wake, exp_hold;
    logic [7:0]  rx_byte, tx_byte;
    logic [17:0] role, exp_role;
    logic [8:0]  dout, ddir, exp_out, exp_dir;
    logic [2:0]  mode, exp_mode;
    int          num_errors, n_compared;

    live_settings_cmd dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_rx_valid(rx_valid),
        .i_rx_sof(rx_sof), .i_rx_byte(rx_byte), .o_rx_ready(rx_ready), .o_tx_valid(tx_valid),
        .o_tx_byte(tx_byte), .o_tx_last(tx_last), .i_tx_ready(tx_ready), .o_pin_role(role),
        .o_default_out(dout), .o_default_dir(ddir), .o_wake_en(wake),
        .o_int_count_mode(mode), .o_hold_bus(hold), .o_settings_loaded(loaded));
    host_report_model host (.i_clk(i_mclk), .i_rx_ready(rx_ready), .i_tx_valid(tx_valid),
        .i_tx_byte(tx_byte), .i_tx_last(tx_last), .o_rx_valid(rx_valid), .o_rx_sof(rx_sof),
        .o_rx_byte(rx_byte), .o_tx_ready(tx_ready));

    // 100 MHz clock
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    task automatic cmp(input string nm, input logic [17:0] e, input logic [17:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic finish_test();
        if (num_errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk_live();
        cmp("role", exp_role, role);
        cmp("out", 18'(exp_out), 18'(dout));
        cmp("dir", 18'(exp_dir), 18'(ddir));
        cmp("wake", 18'(exp_wake), 18'(wake));
        cmp("mode", 18'(exp_mode), 18'(mode));
        cmp("hold", 18'(exp_hold), 18'(hold));
    endtask

    // One report; role code 3 on some pins must leave those roles alone
    task automatic t_cmd(input logic [7:0] code, input int sd, input logic [15:0] out,
                         input logic [15:0] dir, input logic [7:0] opt, input bit slow);
        for (int n = 0; n < 9; n++)
            host.rpt[4+n] = 8'((n + sd) % 4);
        {host.rpt[0], host.rpt[13], host.rpt[14]} = {code, out[7:0], out[15:8]};
        {host.rpt[15], host.rpt[16], host.rpt[17]} = {dir[7:0], dir[15:8], opt};
        host.send();
        // Commit pulse stands only in the cycle right after byte 63 is taken
        if (code == 8'h21) begin
            for (int n = 0; n < 9; n++)
                if ((n + sd) % 4 != 3)
                    exp_role[2*n +: 2] = 2'((n + sd) % 4);
            {exp_out, exp_dir, exp_wake, exp_hold} = {out[8:0], dir[8:0], opt[4], opt[0]};
            exp_mode = (opt[3:1] > 3'h4) ? 3'h0 : opt[3:1];
        end
        cmp("loaded", 18'(code == 8'h21), 18'(loaded));
        chk_live();
        if (code == 8'h21) begin
            host.recv(slow);
            cmp("echo", 18'h21, 18'(host.rsp[0]));
            cmp("status", 18'h0, 18'(host.rsp[1]));
            cmp("last", 18'd63, 18'(host.last_idx));
        end else begin
            repeat (3) @(posedge i_mclk);
            cmp("no_answer", 18'h0, {16'h0, tx_valid, loaded});
        end
    endtask

    // Reset in mid-run: live set and answer side back to their reset values
    task automatic t_reset();
        i_rstn = 1'b0;
        {exp_role, exp_out, exp_dir, exp_wake, exp_mode, exp_hold} = '0;
        @(posedge i_mclk);
        #1;
        chk_live();
        cmp("rst_tx", 18'h0, {7'h0, tx_valid, tx_last, tx_byte, loaded});
        i_rstn = 1'b1;
    endtask

    // Hang guard, well beyond ten reports
    initial begin
        #100000;
        num_errors++;
        finish_test();
    end

    initial begin
        {i_rstn, num_errors, n_compared} = '0;
        {exp_role, exp_out, exp_dir, exp_wake, exp_mode, exp_hold} = '0;
        repeat (3) @(posedge i_mclk);
        #1;
        chk_live();
        cmp("rst_ready", 18'h1, 18'(rx_ready));
        cmp("rst_tx", 18'h0, {7'h0, tx_valid, tx_last, tx_byte, loaded});
        i_rstn = 1'b1;
        // Every counting code, reserved ones too, junk in the ignored bits
        for (int m = 0; m < 8; m++)
            t_cmd(8'h21, m, 16'hfe5a ^ (16'(m) << 7), 16'h02c3 ^ 16'(m),
                  {3'h5, m[0], m[2:0], ~m[0]}, m[0]);
        t_cmd(8'h20, 1, 16'h0155, 16'h01aa, 8'h1f, 1'b0);
        t_reset();
        t_cmd(8'h21, 2, 16'h0133, 16'h00cc, 8'h17, 1'b1);
        finish_test();
    end
endmodule
